// File: common/fetch_dispatch_pkg.sv
// shared constants for the vliw fetch and dispatch front end
package fetch_dispatch_pkg;
  localparam int WORD_W    = 32;
  localparam int FP_WORDS  = 8;
  localparam int FP_W      = WORD_W * FP_WORDS;
  localparam int RES_W     = 64;
  localparam int CNT_W     = 4;
  localparam logic [31:0] FP_BYTES = 32'h0000_0020;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
  // instruction word fields
  localparam int CHAIN_BIT = 0;
  localparam int UNIT_LSB  = 1;
  localparam int UNIT_W    = 3;
  localparam int OP_LSB    = 4;
  localparam int OP_W      = 4;
  localparam int LANE_LSB  = 8;
  localparam int LANE_W    = 2;
  // unit numbering: 0..3 arithmetic/logic/branch, 4..5 multiply, 6..7 load-store
  localparam int MUL_BASE  = 4;
  localparam int MUL_UNITS = 2;
  // multiply unit operations
  localparam logic [3:0] MUL_DUAL16  = 4'h0;
  localparam logic [3:0] MUL_QUAD8   = 4'h1;
  localparam logic [3:0] MUL_16X32   = 4'h2;
  localparam logic [3:0] MUL_DOT2ADD = 4'h3;
  localparam logic [3:0] MUL_DOT2SUB = 4'h4;
  localparam logic [3:0] MUL_DOT4ADD = 4'h5;
  localparam logic [3:0] MUL_BITCNT  = 4'h6;
  localparam logic [3:0] MUL_ROTL    = 4'h7;
  localparam logic [3:0] MUL_GF8     = 4'h8;
  localparam logic [3:0] MUL_SHIFT   = 4'h9;
  localparam logic [7:0] GF_POLY     = 8'h1D;
  // arithmetic/logic/branch and load-store operations
  localparam logic [3:0] ALU_ADD    = 4'h0;
  localparam logic [3:0] ALU_SUB    = 4'h1;
  localparam logic [3:0] ALU_AND    = 4'h2;
  localparam logic [3:0] ALU_OR     = 4'h3;
  localparam logic [3:0] ALU_XOR    = 4'h4;
  localparam logic [3:0] ALU_CMPEQ  = 4'h5;
  localparam logic [3:0] ALU_BRANCH = 4'h6;
  localparam logic [3:0] LS_ADDR    = 4'h7;
  localparam logic [3:0] LS_STORE   = 4'h8;
  // lane modes and access sizes share the lane field
  localparam logic [1:0] LANE_32 = 2'h0;
  localparam logic [1:0] LANE_16 = 2'h1;
  localparam logic [1:0] LANE_8  = 2'h2;
  localparam logic [1:0] SIZE_B  = 2'h0;
  localparam logic [1:0] SIZE_H  = 2'h1;
  localparam logic [1:0] SIZE_W  = 2'h2;
  localparam logic [1:0] SIZE_D  = 2'h3;
endpackage : fetch_dispatch_pkg

// File: core/simd_mul_unit.sv
// packed multiply unit with bit count, rotate, galois and shift
`timescale 1ns/1ps
`default_nettype none
module simd_mul_unit (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        en_in,
  input  wire logic [3:0]  op_in,
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  output var  logic [63:0] result_out
);
  logic [1:0][31:0] p16;
  logic [3:0][15:0] p8;
  logic [3:0][7:0]  gf;
  logic [63:0]      next_result;

  function automatic logic [7:0] gf_mul(input logic [7:0] x,
                                        input logic [7:0] y);
    logic [7:0] acc;
    logic [7:0] s;
    acc = '0;
    s = x;
    for (int i = 0; i < 8; i++) begin
      if (y[i]) acc = acc ^ s;
      s = s[7] ? ((s << 1) ^ fetch_dispatch_pkg::GF_POLY) : (s << 1);
    end
    return acc;
  endfunction : gf_mul

  //////////////////////////////////////////////////////////////////////////
  // lane products
  for (genvar h = 0; h < 2; h++) begin : g_half
    assign p16[h] = a_in[h*16+:16] * b_in[h*16+:16];
  end
  for (genvar q = 0; q < 4; q++) begin : g_byte
    assign p8[q] = a_in[q*8+:8] * b_in[q*8+:8];
    assign gf[q] = gf_mul(a_in[q*8+:8], b_in[q*8+:8]);
  end

  //////////////////////////////////////////////////////////////////////////
  // operation select
  always_comb begin
    next_result = '0;
    case (op_in)
      fetch_dispatch_pkg::MUL_DUAL16:  next_result = {p16[1], p16[0]};
      fetch_dispatch_pkg::MUL_QUAD8:   next_result = p8;
      fetch_dispatch_pkg::MUL_16X32:
        next_result = {16'h0000, 48'(a_in[15:0]) * 48'(b_in)};
      fetch_dispatch_pkg::MUL_DOT2ADD:
        next_result = {32'h0000_0000, p16[0] + p16[1]};
      fetch_dispatch_pkg::MUL_DOT2SUB:
        next_result = {32'h0000_0000, p16[0] - p16[1]};
      fetch_dispatch_pkg::MUL_DOT4ADD:
        next_result = {32'h0000_0000, {16'h0000, p8[0]} + {16'h0000, p8[1]}
                       + {16'h0000, p8[2]} + {16'h0000, p8[3]}};
      fetch_dispatch_pkg::MUL_BITCNT:
        next_result = {58'h0, 6'($countones(a_in))};
      fetch_dispatch_pkg::MUL_ROTL:
        next_result = {32'h0000_0000, (a_in << b_in[4:0])
                       | (a_in >> (6'h20 - {1'b0, b_in[4:0]}))};
      fetch_dispatch_pkg::MUL_GF8:     next_result = {32'h0000_0000, gf};
      fetch_dispatch_pkg::MUL_SHIFT:
        next_result = {32'h0000_0000, b_in[5] ? (a_in >> (6'h0 - b_in[5:0]))
                       : (a_in << b_in[5:0])};
      default:                         next_result = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) result_out <= '0;
    else if (en_in) result_out <= next_result;
  end

  chk_dual_mult: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    en_in && op_in == fetch_dispatch_pkg::MUL_DUAL16 |=>
      result_out[31:0] == $past(a_in[15:0]) * $past(b_in[15:0])
      && result_out[63:32] == $past(a_in[31:16]) * $past(b_in[31:16]))
    else $error("dual multiply result wrong");

  chk_wide_mult: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    en_in && op_in == fetch_dispatch_pkg::MUL_16X32 |=>
      result_out == 64'($past(a_in[15:0])) * 64'($past(b_in)))
    else $error("16 by 32 multiply result wrong");
endmodule : simd_mul_unit
`default_nettype wire

// File: core/simd_alu_unit.sv
// packed arithmetic, logic, branch and load-store formatting unit
`timescale 1ns/1ps
`default_nettype none
module simd_alu_unit (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        en_in,
  input  wire logic [3:0]  op_in,
  input  wire logic [1:0]  lane_in,
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  output var  logic [63:0] result_out
);
  logic [31:0] sum;
  logic [3:0]  byte_eq;
  logic [31:0] eq_mask;
  logic [7:0]  size_mask;
  logic [31:0] addr;
  logic [63:0] next_result;
  logic        sub;
  logic        carry;
  logic        cin;
  logic [8:0]  part;

  //////////////////////////////////////////////////////////////////////////
  // lane adder: carries break at lane edges
  always_comb begin
    sub = (op_in == fetch_dispatch_pkg::ALU_SUB);
    carry = 1'b0;
    sum = '0;
    cin = 1'b0;
    part = '0;
    for (int j = 0; j < 4; j++) begin
      cin = carry;
      if (j == 0 || lane_in == fetch_dispatch_pkg::LANE_8
          || (lane_in == fetch_dispatch_pkg::LANE_16 && j == 2)) cin = sub;
      part = {1'b0, a_in[j*8+:8]} + {1'b0, sub ? ~b_in[j*8+:8] : b_in[j*8+:8]}
             + {8'h00, cin};
      sum[j*8+:8] = part[7:0];
      carry = part[8];
    end
  end

  for (genvar q = 0; q < 4; q++) begin : g_eq
    assign byte_eq[q] = (a_in[q*8+:8] == b_in[q*8+:8]);
  end

  always_comb begin
    eq_mask = '0;
    case (lane_in)
      fetch_dispatch_pkg::LANE_8:  eq_mask = {{8{byte_eq[3]}}, {8{byte_eq[2]}},
                                              {8{byte_eq[1]}}, {8{byte_eq[0]}}};
      fetch_dispatch_pkg::LANE_16: eq_mask = {{16{&byte_eq[3:2]}},
                                              {16{&byte_eq[1:0]}}};
      default:                     eq_mask = {32{&byte_eq}};
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // load-store sizing: byte address, enables, store data replicated below doubleword
  assign addr = a_in + b_in;
  always_comb begin
    case (lane_in)
      fetch_dispatch_pkg::SIZE_B: size_mask = 8'h01;
      fetch_dispatch_pkg::SIZE_H: size_mask = 8'h03;
      fetch_dispatch_pkg::SIZE_W: size_mask = 8'h0F;
      default:                    size_mask = 8'hFF;
    endcase
  end

  always_comb begin
    next_result = '0;
    case (op_in)
      fetch_dispatch_pkg::ALU_ADD,
      fetch_dispatch_pkg::ALU_SUB:   next_result = {32'h0000_0000, sum};
      fetch_dispatch_pkg::ALU_AND:   next_result = {32'h0000_0000, a_in & b_in};
      fetch_dispatch_pkg::ALU_OR:    next_result = {32'h0000_0000, a_in | b_in};
      fetch_dispatch_pkg::ALU_XOR:   next_result = {32'h0000_0000, a_in ^ b_in};
      fetch_dispatch_pkg::ALU_CMPEQ: next_result = {32'h0000_0000, eq_mask};
      fetch_dispatch_pkg::ALU_BRANCH:
        next_result = {31'h0, |a_in, b_in};
      fetch_dispatch_pkg::LS_ADDR:
        next_result = {24'h00_0000, 8'(size_mask << addr[2:0]), addr};
      fetch_dispatch_pkg::LS_STORE: begin
        case (lane_in)
          fetch_dispatch_pkg::SIZE_B: next_result = {8{a_in[7:0]}};
          fetch_dispatch_pkg::SIZE_H: next_result = {4{a_in[15:0]}};
          fetch_dispatch_pkg::SIZE_W: next_result = {2{a_in}};
          default:                    next_result = {b_in, a_in};
        endcase
      end
      default:                       next_result = '0;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) result_out <= '0;
    else if (en_in) result_out <= next_result;
  end

  chk_lane_add: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    en_in && op_in == fetch_dispatch_pkg::ALU_ADD
    && lane_in == fetch_dispatch_pkg::LANE_8 |=>
      result_out[15:8] == 8'($past(a_in[15:8]) + $past(b_in[15:8])))
    else $error("quad byte add leaked a carry");
endmodule : simd_alu_unit
`default_nettype wire

// File: core/vliw_fetch_dispatch.sv
// fetch packet splitter and execute packet dispatcher with its units
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - fetch whole 256-bit packets of eight words
// - low bit one chains next word in
// - low bit zero closes the execute packet
// - at most eight words, distinct units, together (two words naming one unit are still issued and raise unit_conflict_out)
// - execute packets may span two fetch packets
// - issue one execute packet per clock
// - fetch next only after current fully dispatched (words of a packet spanning into the next still wait in carry)
// - one to eight execute packets per fetch
// - multiply: two 16x16 or four 8x8
// - multiply: 16x32, dot products with add/sub
// - multiply unit: bitcount, rotate, galois, shift
// - arithmetic, logic, branch results every cycle
// - lanes of 32, 2x16 or 4x8 bits
// - byte to doubleword load-store sizes
module vliw_fetch_dispatch #(
  parameter logic [31:0] START_ADDR = fetch_dispatch_pkg::ADDR_RESET
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  output var  logic         fetch_req_out,
  output var  logic [31:0]  fetch_addr_out,
  input  wire logic         fetch_valid_in,
  input  wire logic [255:0] fetch_data_in,
  output var  logic         issue_valid_out,
  output var  logic [3:0]   issue_count_out,
  output var  logic [255:0] issue_words_out,
  output var  logic [7:0]   unit_valid_out,
  output var  logic         unit_conflict_out,
  input  wire logic [255:0] unit_a_in,
  input  wire logic [255:0] unit_b_in,
  output wire logic [511:0] unit_result_out
);
  localparam int W = fetch_dispatch_pkg::WORD_W;
  localparam int N = fetch_dispatch_pkg::FP_WORDS;
  localparam int C = fetch_dispatch_pkg::CNT_W;
  localparam logic [3:0] FULL = 4'(fetch_dispatch_pkg::FP_WORDS);

  if (START_ADDR[4:0] != 5'h00) begin : g_bad_start
    $error("start address must be fetch packet aligned");
  end

  logic [N-1:0][W-1:0] fp;
  logic                fp_valid;
  logic [C-1:0]        pos;
  logic [N-1:0][W-1:0] carry;
  logic [C-1:0]        carry_cnt;
  logic                pending;
  logic [C-1:0]        room;
  logic [C-1:0]        next_take;
  logic [C-1:0]        next_count;
  logic                stop;
  logic                close;
  logic [N-1:0][W-1:0] next_slot;
  logic [N-1:0][W-1:0] next_unit_word;
  logic [N-1:0]        next_unit_valid;
  logic                next_conflict;
  logic [N-1:0][W-1:0] unit_word;
  logic [2:0]          u;
  logic                chain_ok;
  logic                end_ok;

  //////////////////////////////////////////////////////////////////////////
  // fetch request: one packet outstanding, only once the last is spent
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fetch_req_out <= 1'b0;
      pending <= 1'b0;
      fetch_addr_out <= START_ADDR;
    end else begin
      fetch_req_out <= 1'b0;
      if (pending && fetch_valid_in) begin
        pending <= 1'b0;
        fetch_addr_out <= fetch_addr_out + fetch_dispatch_pkg::FP_BYTES;
      end else if (!fp_valid && !pending) begin
        fetch_req_out <= 1'b1;
        pending <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // chain scan from the current word
  always_comb begin
    room = FULL - carry_cnt;
    next_take = '0;
    stop = 1'b0;
    for (int i = 0; i < N; i++) begin
      if (fp_valid && !stop && 4'(i) >= pos && 4'(i) - pos < room) begin
        next_take = next_take + 4'h1;
        if (!fp[i][fetch_dispatch_pkg::CHAIN_BIT]) stop = 1'b1;
      end
    end
    next_count = carry_cnt + next_take;
    close = fp_valid && (stop || next_count == FULL);
  end

  // packet: held words first, then the new ones
  always_comb begin
    for (int k = 0; k < N; k++) begin
      next_slot[k] = carry[k];
      if (4'(k) >= carry_cnt) next_slot[k] = fp[3'(4'(k) - carry_cnt + pos)];
      if (4'(k) >= next_count) next_slot[k] = '0;
    end
  end

  // route each word to the unit it names
  always_comb begin
    next_unit_word = '0;
    next_unit_valid = '0;
    next_conflict = 1'b0;
    u = '0;
    for (int k = 0; k < N; k++) begin
      if (4'(k) < next_count) begin
        u = next_slot[k][fetch_dispatch_pkg::UNIT_LSB+:fetch_dispatch_pkg::UNIT_W];
        if (next_unit_valid[u]) next_conflict = 1'b1;
        next_unit_valid[u] = 1'b1;
        next_unit_word[u] = next_slot[k];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // fetch packet buffer and read position
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fp <= '0;
      fp_valid <= 1'b0;
      pos <= '0;
    end else if (pending && fetch_valid_in) begin
      fp <= fetch_data_in;
      fp_valid <= 1'b1;
      pos <= '0;
    end else if (fp_valid) begin
      pos <= pos + next_take;
      if (pos + next_take == FULL) fp_valid <= 1'b0;
    end
  end

  // words of a packet that runs off the end wait here
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      carry <= '0;
      carry_cnt <= '0;
    end else if (fp_valid) begin
      if (close) begin
        carry_cnt <= '0;
      end else begin
        carry <= next_slot;
        carry_cnt <= next_count;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // issue register: one execute packet per cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      issue_valid_out <= 1'b0;
      issue_count_out <= '0;
      issue_words_out <= '0;
      unit_valid_out <= '0;
      unit_conflict_out <= 1'b0;
      unit_word <= '0;
    end else begin
      issue_valid_out <= close;
      unit_valid_out <= close ? next_unit_valid : '0;
      unit_conflict_out <= close && next_conflict;
      if (close) begin
        issue_count_out <= next_count;
        issue_words_out <= next_slot;
        unit_word <= next_unit_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // functional units
  for (genvar g = 0; g < N; g++) begin : g_unit
    if (g >= fetch_dispatch_pkg::MUL_BASE
        && g < fetch_dispatch_pkg::MUL_BASE + fetch_dispatch_pkg::MUL_UNITS)
    begin : g_mul
      simd_mul_unit u_mul (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .en_in      (unit_valid_out[g]),
        .op_in      (unit_word[g][fetch_dispatch_pkg::OP_LSB+:4]),
        .a_in       (unit_a_in[g*32+:32]),
        .b_in       (unit_b_in[g*32+:32]),
        .result_out (unit_result_out[g*64+:64])
      );
    end else begin : g_alu
      simd_alu_unit u_alu (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .en_in      (unit_valid_out[g]),
        .op_in      (unit_word[g][fetch_dispatch_pkg::OP_LSB+:4]),
        .lane_in    (unit_word[g][fetch_dispatch_pkg::LANE_LSB+:2]),
        .a_in       (unit_a_in[g*32+:32]),
        .b_in       (unit_b_in[g*32+:32]),
        .result_out (unit_result_out[g*64+:64])
      );
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks on the issued packet
  always_comb begin
    chain_ok = 1'b1;
    for (int k = 0; k < N - 1; k++) begin
      if (4'(k + 1) < issue_count_out && !issue_words_out[k*W]) chain_ok = 1'b0;
    end
    end_ok = (issue_count_out == FULL) || (issue_count_out != '0
             && !issue_words_out[3'(issue_count_out - 4'h1)*W]);
  end

  chk_fetch_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    pending && fetch_valid_in |=> fp_valid && pos == '0 && fp == $past(fetch_data_in))
    else $error("fetch packet not loaded whole");

  chk_chain_link: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    issue_valid_out |-> chain_ok)
    else $error("chained word split from its packet");

  chk_chain_break: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    issue_valid_out |-> end_ok)
    else $error("packet did not end at a cleared chain bit");

  chk_packet_size: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    issue_valid_out |-> issue_count_out != '0 && issue_count_out <= FULL)
    else $error("execute packet size out of range");

  chk_span_carry: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fp_valid && !close && pos + next_take == FULL |=>
      !fp_valid && carry_cnt == $past(next_count))
    else $error("spanning words not carried");

  chk_issue_rate: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fp_valid && carry_cnt == '0 && !fp[pos[2:0]][0] |=>
      issue_valid_out && issue_count_out == 4'h1)
    else $error("single word packet not issued next cycle");

  chk_fetch_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fp_valid |-> !fetch_req_out ##1 !fetch_req_out)
    else $error("fetch requested with words still pending");

  chk_pos_range: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    fp_valid |-> pos < FULL)
    else $error("read position past the fetch packet");

  chk_carry_whole: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    carry_cnt != '0 && !fp_valid |=> !issue_valid_out)
    else $error("partial spanning packet issued");
endmodule : vliw_fetch_dispatch
`default_nettype wire

// File: dv/prog_mem_model.sv
// program memory model answering fetch requests with 256-bit packets
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
  input  wire logic         sys_clk_in,
  input  wire logic         rst_in,
  input  wire logic         req_in,
  input  wire logic [31:0]  addr_in,
  input  wire logic [3:0]   lat_in,
  output var  logic         valid_out,
  output var  logic [255:0] data_out
);
  logic [255:0] mem [4];
  logic         busy;
  logic [3:0]   wait_cnt;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy      <= 1'b0;
      wait_cnt  <= 4'h0;
      valid_out <= 1'b0;
      data_out  <= '0;
    end else begin
      valid_out <= 1'b0;
      // released bus toggles so stale data never looks valid
      data_out  <= ~data_out;
      if (req_in && lat_in == 4'h0) begin
        valid_out <= 1'b1;
        data_out  <= mem[addr_in[6:5]];
      end else if (req_in) begin
        busy     <= 1'b1;
        wait_cnt <= lat_in;
      end else if (busy) begin
        if (wait_cnt == 4'h1) begin
          valid_out <= 1'b1;
          data_out  <= mem[addr_in[6:5]];
          busy      <= 1'b0;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
      end
    end
  end
endmodule : prog_mem_model
`default_nettype wire

// File: dv/tb_top.sv
// testbench for the fetch and dispatch front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [31:0] CHAINS = 32'hFF7F00F9;
  localparam logic [31:0] OPA    = 32'h80F07F01;
  localparam logic [31:0] OPB    = 32'h03118105;
  logic         sys_clk_in, rst_in, fetch_valid_in, fetch_req_out;
  logic         issue_valid_out, unit_conflict_out;
  logic [3:0]   lat, issue_count_out;
  logic [31:0]  fetch_addr_out;
  logic [7:0]   unit_valid_out;
  logic [255:0] fetch_data_in, unit_a_in, unit_b_in, issue_words_out;
  logic [511:0] unit_result_out;
  int           num_errors, num_checks;
  int           ep_cnt[$], ep_pkt[$], cum[4];
  logic [255:0] ep_words[$];
  logic [7:0]   ep_mask[$];
  logic         ep_conf[$];
  ////////////////////////////////////////////////////////////////////////////
  vliw_fetch_dispatch i_vliw_fetch_dispatch (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .fetch_req_out(fetch_req_out), .fetch_addr_out(fetch_addr_out),
    .fetch_valid_in(fetch_valid_in), .fetch_data_in(fetch_data_in),
    .issue_valid_out(issue_valid_out), .issue_count_out(issue_count_out),
    .issue_words_out(issue_words_out), .unit_valid_out(unit_valid_out),
    .unit_conflict_out(unit_conflict_out), .unit_a_in(unit_a_in),
    .unit_b_in(unit_b_in), .unit_result_out(unit_result_out));
  prog_mem_model i_prog_mem_model (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(fetch_req_out),
    .addr_in(fetch_addr_out), .lat_in(lat), .valid_out(fetch_valid_in),
    .data_out(fetch_data_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] mkw(input int w);
    logic [2:0] u;
    logic [3:0] op;
    logic [1:0] ln;
    u  = (w == 1) ? 3'h0 : 3'(w % 8);
    op = fetch_dispatch_pkg::ALU_ADD;
    ln = fetch_dispatch_pkg::LANE_32;
    if (w / 8 == 2) begin
      case (u)
        3'h0: op = fetch_dispatch_pkg::ALU_ADD;
        3'h1: op = fetch_dispatch_pkg::ALU_SUB;
        3'h2: op = fetch_dispatch_pkg::ALU_XOR;
        3'h3: op = fetch_dispatch_pkg::ALU_BRANCH;
        3'h4: op = fetch_dispatch_pkg::MUL_ROTL;
        3'h5: op = fetch_dispatch_pkg::MUL_BITCNT;
        3'h6: op = fetch_dispatch_pkg::LS_ADDR;
        default: op = fetch_dispatch_pkg::LS_STORE;
      endcase
      if (u == 3'h0) ln = fetch_dispatch_pkg::LANE_8;
      if (u == 3'h1) ln = fetch_dispatch_pkg::LANE_16;
    end
    if (w / 8 == 3 && u == 3'h4) op = fetch_dispatch_pkg::MUL_16X32;
    if (w / 8 == 3 && u == 3'h5) op = fetch_dispatch_pkg::MUL_DOT2SUB;
    return {22'h2A0000 | 22'(w), ln, op, u, CHAINS[w]};
  endfunction : mkw
  task automatic fail(input string m);
    $display("mismatch %0t %s", $time, m);
    num_errors++;
  endtask : fail
  task automatic build_ref();
    logic [255:0] wd;
    logic [7:0]   mk;
    logic         cf;
    logic [31:0]  x;
    int           n, tot;
    n = 0; tot = 0; wd = '0; mk = '0; cf = 1'b0;
    for (int w = 0; w < 32; w++) begin
      x = mkw(w);
      i_prog_mem_model.mem[w / 8][32 * (w % 8) +: 32] = x;
      wd[32 * n +: 32] = x;
      cf = cf | mk[x[3:1]];
      mk[x[3:1]] = 1'b1;
      n++;
      if (x[0] == 1'b0 || n == 8) begin
        ep_cnt.push_back(n); ep_pkt.push_back(w / 8); ep_words.push_back(wd);
        ep_mask.push_back(mk); ep_conf.push_back(cf);
        tot += n; n = 0; wd = '0; mk = '0; cf = 1'b0;
      end
      if (w % 8 == 7) cum[w / 8] = tot;
    end
  endtask : build_ref
  task automatic check_units();
    logic [31:0] e8, e16, rot;
    for (int i = 0; i < 4; i++) e8[8 * i +: 8] = OPA[8 * i +: 8] + OPB[8 * i +: 8];
    for (int i = 0; i < 2; i++) e16[16*i +: 16] = OPA[16*i +: 16] - OPB[16*i +: 16];
    rot = (OPA << OPB[4:0]) | (OPA >> (6'h20 - 6'(OPB[4:0])));
    num_checks += 8;
    if (unit_result_out[31:0] !== e8) fail("quad byte add");
    if (unit_result_out[95:64] !== e16) fail("dual half sub");
    if (unit_result_out[159:128] !== (OPA ^ OPB)) fail("xor");
    if (unit_result_out[224:192] !== {|OPA, OPB}) fail("branch");
    if (unit_result_out[287:256] !== rot) fail("rotate");
    if (unit_result_out[351:320] !== 32'($countones(OPA))) fail("bitcnt");
    if (unit_result_out[415:384] !== OPA + OPB) fail("ls address");
    if (unit_result_out[511:448] !== {8{OPA[7:0]}}) fail("store");
  endtask : check_units
  task automatic check_wide();
    num_checks += 2;
    if (unit_result_out[319:256] !== 64'(OPA[15:0]) * 64'(OPB))
      fail("wide multiply");
    if (unit_result_out[351:320] !== 32'(OPA[15:0]) * 32'(OPB[15:0])
        - 32'(OPA[31:16]) * 32'(OPB[31:16])) fail("dual multiply sub");
  endtask : check_wide
  task automatic scn_stream(input logic [3:0] l);
    int ei, reqs, issued, cyc, last;
    logic pend;
    ei = 0; reqs = 0; issued = 0; cyc = 0; last = 0; pend = 1'b0;
    @(posedge sys_clk_in);
    lat    <= l;
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    while (ei < ep_cnt.size() && cyc < 600) begin
      @(negedge sys_clk_in);
      cyc++;
      if (pend) check_units();
      pend = 1'b0;
      if (fetch_req_out === 1'b1) begin
        num_checks += 2;
        if (reqs > 0 && issued != cum[reqs - 1]) fail("early fetch");
        if (fetch_addr_out !== 32'(reqs) * fetch_dispatch_pkg::FP_BYTES) fail("addr");
        reqs++;
      end
      if (issue_valid_out === 1'b1) begin
        num_checks += 5;
        if (issue_count_out !== 4'(ep_cnt[ei])) fail("count");
        if (issue_words_out !== ep_words[ei]) fail("words");
        if (unit_valid_out !== ep_mask[ei]) fail("unit mask");
        if (unit_conflict_out !== ep_conf[ei]) fail("conflict flag");
        if (ei > 0 && ep_pkt[ei] == ep_pkt[ei - 1] && cyc != last + 1) fail("gap");
        pend = (ep_pkt[ei] == 2);
        issued += ep_cnt[ei];
        last = cyc;
        ei++;
      end
    end
    if (ei < ep_cnt.size()) fail("timeout waiting for issue");
    @(negedge sys_clk_in);
    check_wide();
  endtask : scn_stream
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    rst_in = 1'b1; lat = 4'h0; num_errors = 0; num_checks = 0;
    unit_a_in <= {8{OPA}};
    unit_b_in <= {8{OPB}};
    build_ref();
    scn_stream(4'h0);
    scn_stream(4'h3);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
